// file: logic/pmou_pkg.sv
// Purpose: constants and carriers for the power-management option bank
// Assumes: 8-bit registers on a plain strobe port, 125 MHz clock
// Notes:   offsets are the bank's byte addresses
package pmou_pkg;
    localparam logic [7:0] OFS_SPARE_5F   = 8'h5f;
    localparam logic [7:0] OFS_FAN_SPKR   = 8'h60;
    localparam logic [7:0] OFS_CPU_THERM  = 8'h61;
    localparam logic [7:0] OFS_SCI_MIRROR = 8'h62;
    localparam logic [7:0] OFS_SPARE_63   = 8'h63;
    localparam logic [7:0] OFS_SPARE_64   = 8'h64;
    localparam logic [7:0] OFS_USB_CTRL   = 8'h65;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h70;
    localparam logic [7:0] OFS_IRQ_MASK   = 8'h71;

    localparam logic [7:0] RST_SPARE_5F   = 8'h00;
    localparam logic [7:0] RST_FAN_SPKR   = 8'h00;
    localparam logic [7:0] RST_CPU_THERM  = 8'h08;
    localparam logic [7:0] RST_SPARE_63   = 8'h05;
    localparam logic [7:0] RST_SPARE_64   = 8'h05;
    localparam logic [7:0] RST_USB_CTRL   = 8'h34;

    // first options register fields
    localparam int B_ALERT_FAN = 0;
    localparam int B_HOT_FAN   = 1;
    localparam int B_FAN1_PIN  = 2;
    localparam int B_FAN2_PIN  = 3;
    localparam int B_FAN3_PIN  = 4;
    localparam int B_SPKR_PIN  = 5;
    localparam int B_FAN0_PIN  = 6;
    // second options register fields
    localparam int B_FW_SPARE  = 0;
    localparam int B_IOAPIC_HS = 1;
    localparam int B_BM_MON    = 2;
    localparam int B_USE_PROCESSOR_RESET_OUT = 3;
    localparam int B_HOT_STS   = 4;
    localparam int B_USB_WAKE  = 6;
    // usb control fields
    localparam int B_PHY_PDN   = 0;
    localparam int B_RES_WAKE  = 2;
    localparam int B_SOFT_RST  = 4;
    localparam int B_DEEP_RST  = 5;
    localparam int B_CONN_WAKE = 6;
    localparam int B_TICK_SEL  = 7;
    // interrupt status fields
    localparam int I_THERM_WARN = 0;
    localparam int I_BM_ACT     = 1;
    localparam int I_WAKE       = 2;
    localparam int IRQ_BITS     = 3;

    // sequencing ticks
    localparam int CLK_PERIOD_PS  = 8000;
    localparam int TICK_FAST_NS   = 8000;
    localparam int TICK_SLOW_US   = 1000;
    localparam int TICK_FAST_CYC  = TICK_FAST_NS * 1000 / CLK_PERIOD_PS;
    localparam int TICK_SLOW_CYC  = TICK_SLOW_US * 1000000 / CLK_PERIOD_PS;
    localparam int TICK_W         = 17;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pmou_req_s;

    typedef struct packed {
        logic thermal_alert;
        logic processor_hot;
        logic bus_master_request;
        logic sb_bus_master;
        logic usb_resume;
        logic usb_connect;
        logic deep_resume;
        logic soft_bus_reset;
        logic system_reset;
        logic sci;
    } pmou_evt_s;
endpackage

// file: logic/pmou_sync.sv
// Purpose: two-flop synchroniser for a bundle of pin levels
// Assumes: inputs are asynchronous levels
// Notes:   first stage is read only by the second
`timescale 1ns/10ps
module pmou_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         reset_n_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta;

    // double flop against metastability
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            meta   <= '0;
            sync_o <= '0;
        end
        else
        begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end
endmodule

// file: logic/pmou_tick.sv
// Purpose: sleep-to-working sequencing tick generator
// Assumes: 125 MHz clock
// Notes:   one-cycle enable pulse, period chosen by slow_i
`timescale 1ns/10ps
module pmou_tick
    import pmou_pkg::*;
#(
    parameter int SLOW_CYC = TICK_SLOW_CYC
) (
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    input  wire logic slow_i,
    output logic      tick_o
);
    logic [TICK_W-1:0] count;
    logic [TICK_W-1:0] limit;

    // the period switch acts at once; a count at or past the new limit wraps and ticks on the next cycle
    assign limit = slow_i ? TICK_W'(SLOW_CYC - 1) : TICK_W'(TICK_FAST_CYC - 1);

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            count  <= '0;
            tick_o <= 1'b0;
        end
        else if (count >= limit)
        begin
            count  <= '0;
            tick_o <= 1'b1;
        end
        else
        begin
            count  <= count + TICK_W'(1);
            tick_o <= 1'b0;
        end
    end
endmodule

// file: logic/pmou_bank.sv
// Purpose: power-management option register bank with fan, pin, reset
//          and usb sleep/wake controls
// Assumes: pins pass two flops here; strobe port on the same clock
// Notes:   read data stand one cycle after the read strobe
`timescale 1ns/10ps
module pmou_bank
    import pmou_pkg::*;
#(
    parameter int SLOW_CYC = TICK_SLOW_CYC
) (
    input  wire logic              clk_i,
    input  wire logic              reset_n_i,
    input  wire pmou_pkg::pmou_req_s req_i,
    output logic [7:0]             rdata_o,
    input  wire pmou_pkg::pmou_evt_s pins_i,
    input  wire logic              sleep_s3_i,
    input  wire logic              sleep_deep_i,
    input  wire logic              wake_seq_i,
    input  wire logic              ioapic_irq_i,
    input  wire logic [3:0]        gpio_fan_in_i,
    input  wire logic              gpio_spkr_in_i,
    input  wire logic              fan_pwm_i,
    input  wire logic              speaker_i,
    output logic [3:0]             fan_pin_o,
    output logic                   spkr_pin_o,
    output logic                   ioapic_handshake_o,
    output logic                   bus_master_activity_o,
    output logic                   processor_reset_out_o,
    output logic                   processor_init_o,
    output logic                   thermal_warning_status_o,
    output logic                   throttle_o,
    output logic                   usb_phy_powerdown_o,
    output logic                   usb_reset_o,
    output logic                   wake_o,
    output logic                   wake_tick_o,
    output logic                   irq_o
);
    logic [7:0] spare_5f;
    logic [7:0] fan_spkr;
    logic [7:0] cpu_therm;
    logic [7:0] spare_63;
    logic [7:0] spare_64;
    logic [7:0] usb_ctrl;
    logic [IRQ_BITS-1:0] irq_status;
    logic [IRQ_BITS-1:0] irq_mask;
    logic [IRQ_BITS-1:0] irq_event;
    logic [$bits(pmou_evt_s)-1:0] pins_raw;
    pmou_evt_s  pin;
    logic       full_fan;
    logic       warn_set;
    logic       bm_act;
    logic       wake_req;
    logic       tick;
    logic [7:0] next_rdata;

    function automatic logic hit(input pmou_req_s r, input logic [7:0] ofs);
        hit = r.wr && (r.addr == ofs);
    endfunction

    // every pin level crosses two flops before use
    pmou_sync #(.W($bits(pmou_evt_s))) u_sync (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .async_i   (pins_i),
        .sync_o    (pins_raw)
    );
    assign pin = pmou_evt_s'(pins_raw);

    pmou_tick #(.SLOW_CYC(SLOW_CYC)) u_tick (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .slow_i    (usb_ctrl[B_TICK_SEL]),
        .tick_o    (tick)
    );

    // option registers; reserved bits kept as storage for readback
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            spare_5f  <= RST_SPARE_5F;
            fan_spkr  <= RST_FAN_SPKR;
            cpu_therm <= RST_CPU_THERM;
            spare_63  <= RST_SPARE_63;
            spare_64  <= RST_SPARE_64;
            usb_ctrl  <= RST_USB_CTRL;
        end
        else
        begin
            if (hit(req_i, OFS_SPARE_5F))
                spare_5f <= req_i.wdata;
            if (hit(req_i, OFS_FAN_SPKR))
                fan_spkr <= req_i.wdata;
            if (hit(req_i, OFS_CPU_THERM))
                cpu_therm <= req_i.wdata;
            if (hit(req_i, OFS_SPARE_63))
                spare_63 <= req_i.wdata;
            if (hit(req_i, OFS_SPARE_64))
                spare_64 <= req_i.wdata;
            if (hit(req_i, OFS_USB_CTRL))
                usb_ctrl <= req_i.wdata;
        end
    end

    // readback mux; unmapped offsets read zero
    always_comb
    begin
        next_rdata = 8'h00;
        unique case (req_i.addr)
            OFS_SPARE_5F:   next_rdata = spare_5f;
            OFS_FAN_SPKR:   next_rdata = fan_spkr;
            OFS_CPU_THERM:  next_rdata = cpu_therm;
            OFS_SCI_MIRROR: next_rdata = {7'h00, pin.sci};
            OFS_SPARE_63:   next_rdata = spare_63;
            OFS_SPARE_64:   next_rdata = spare_64;
            OFS_USB_CTRL:   next_rdata = usb_ctrl;
            OFS_IRQ_STATUS: next_rdata = {5'h00, irq_status};
            OFS_IRQ_MASK:   next_rdata = {5'h00, irq_mask};
            default:        next_rdata = 8'h00;
        endcase
    end

    // data stand only in the cycle after the strobe
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            rdata_o <= 8'h00;
        else if (req_i.rd)
            rdata_o <= next_rdata;
        else
            rdata_o <= 8'h00;
    end

    // fan override and pin muxing
    assign full_fan = (fan_spkr[B_ALERT_FAN] && pin.thermal_alert)
                   || (fan_spkr[B_HOT_FAN] && pin.processor_hot);

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            fan_pin_o  <= 4'h0;
            spkr_pin_o <= 1'b0;
        end
        else
        begin
            // pins not handed over keep their gpio drive
            fan_pin_o[0] <= fan_spkr[B_FAN0_PIN]
                ? (full_fan | fan_pwm_i) : gpio_fan_in_i[0];
            fan_pin_o[1] <= fan_spkr[B_FAN1_PIN]
                ? (full_fan | fan_pwm_i) : gpio_fan_in_i[1];
            fan_pin_o[2] <= fan_spkr[B_FAN2_PIN]
                ? (full_fan | fan_pwm_i) : gpio_fan_in_i[2];
            fan_pin_o[3] <= fan_spkr[B_FAN3_PIN]
                ? (full_fan | fan_pwm_i) : gpio_fan_in_i[3];
            spkr_pin_o   <= fan_spkr[B_SPKR_PIN]
                ? speaker_i : gpio_spkr_in_i;
        end
    end

    // cpu-side controls
    assign warn_set = cpu_therm[B_HOT_STS] && pin.processor_hot;
    assign bm_act   = cpu_therm[B_BM_MON]
                   && (pin.bus_master_request || pin.sb_bus_master);

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ioapic_handshake_o    <= 1'b0;
            bus_master_activity_o <= 1'b0;
            processor_reset_out_o <= 1'b0;
            processor_init_o      <= 1'b0;
            throttle_o            <= 1'b0;
        end
        else
        begin
            ioapic_handshake_o <= cpu_therm[B_IOAPIC_HS]
                && ioapic_irq_i;
            bus_master_activity_o <= bm_act;
            processor_reset_out_o <= pin.system_reset
                && cpu_therm[B_USE_PROCESSOR_RESET_OUT];
            processor_init_o <= pin.system_reset
                && !cpu_therm[B_USE_PROCESSOR_RESET_OUT];
            throttle_o <= warn_set;
        end
    end

    // usb sleep, wake and reset controls
    assign wake_req =
        (usb_ctrl[B_RES_WAKE] && sleep_s3_i && pin.usb_resume)
     || (usb_ctrl[B_CONN_WAKE] && pin.usb_connect)
     || (!usb_ctrl[B_PHY_PDN] && sleep_deep_i && pin.usb_resume);

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            usb_phy_powerdown_o <= 1'b0;
            usb_reset_o         <= 1'b0;
            wake_o              <= 1'b0;
            wake_tick_o         <= 1'b0;
        end
        else
        begin
            usb_phy_powerdown_o <= usb_ctrl[B_PHY_PDN]
                && sleep_deep_i;
            usb_reset_o <= (usb_ctrl[B_SOFT_RST] && pin.soft_bus_reset)
                || (usb_ctrl[B_DEEP_RST] && pin.deep_resume);
            wake_o      <= wake_req;
            wake_tick_o <= wake_seq_i && tick;
        end
    end

    // sticky event flags; a new event beats the write-one clear
    assign irq_event = {wake_req, bm_act, warn_set};

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            irq_status <= '0;
            irq_mask   <= '0;
        end
        else
        begin
            if (hit(req_i, OFS_IRQ_MASK))
                irq_mask <= req_i.wdata[IRQ_BITS-1:0];
            irq_status <= (irq_status
                & ~(hit(req_i, OFS_IRQ_STATUS)
                    ? req_i.wdata[IRQ_BITS-1:0] : '0))
                | irq_event;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            irq_o                    <= 1'b0;
            thermal_warning_status_o <= 1'b0;
        end
        else
        begin
            irq_o <= |(irq_status & irq_mask);
            thermal_warning_status_o <= irq_status[I_THERM_WARN]
                | warn_set;
        end
    end

    // checks
    chk_full_fan_alert: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (fan_spkr[B_ALERT_FAN] && fan_spkr[B_FAN0_PIN] && pin.thermal_alert)
        |=> fan_pin_o[0])
        else $error("fan 0 not full on thermal alert");
    chk_full_fan_hot: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (fan_spkr[B_HOT_FAN] && fan_spkr[B_FAN1_PIN] && pin.processor_hot)
        |=> fan_pin_o[1])
        else $error("fan 1 not full on processor hot");
    chk_gpio_kept: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        !fan_spkr[B_FAN2_PIN] |=> fan_pin_o[2] == $past(gpio_fan_in_i[2]))
        else $error("fan 2 pin lost gpio function");
    chk_spkr_route: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        fan_spkr[B_SPKR_PIN] |=> spkr_pin_o == $past(speaker_i))
        else $error("speaker not routed");
    chk_reset_select: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        pin.system_reset |=> (processor_reset_out_o != processor_init_o))
        else $error("reset and init both or neither");
    chk_warn_status: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        warn_set |=> thermal_warning_status_o && throttle_o)
        else $error("thermal warning not raised");
    chk_no_hot_warn: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        !cpu_therm[B_HOT_STS] |=> !throttle_o)
        else $error("throttle without enable");
    chk_usb_soft_rst: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (usb_ctrl[B_SOFT_RST] && pin.soft_bus_reset) |=> usb_reset_o)
        else $error("usb not reset by soft bus reset");
    chk_phy_pdn: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (!usb_ctrl[B_PHY_PDN]) |=> !usb_phy_powerdown_o)
        else $error("phy powered down while disabled");
    chk_readback: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (req_i.wr && req_i.addr == OFS_USB_CTRL)
        ##1 (req_i.rd && req_i.addr == OFS_USB_CTRL && !req_i.wr)
        |=> rdata_o == $past(req_i.wdata, 2))
        else $error("usb control readback wrong");
    chk_tick_fast: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        $rose(tick) && !usb_ctrl[B_TICK_SEL] |=> !tick [*8])
        else $error("fast tick too frequent");
    chk_hs_gate: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        !cpu_therm[B_IOAPIC_HS] |=> !ioapic_handshake_o)
        else $error("handshake without enable");
    chk_bm_request: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (cpu_therm[B_BM_MON] && pin.bus_master_request)
        |=> bus_master_activity_o)
        else $error("bus master request not seen as activity");
    chk_warn_sticky: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        warn_set |=> irq_status[I_THERM_WARN])
        else $error("thermal warning status lost to clear");
    chk_hib_wake_block: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (usb_ctrl[B_PHY_PDN] && !usb_ctrl[B_CONN_WAKE] && !sleep_s3_i)
        |=> !wake_o)
        else $error("hibernate wake while phy power-down set");
    chk_resume_wake: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (usb_ctrl[B_RES_WAKE] && sleep_s3_i && pin.usb_resume) |=> wake_o)
        else $error("usb resume did not wake from suspend");
    chk_deep_reset: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (usb_ctrl[B_DEEP_RST] && pin.deep_resume) |=> usb_reset_o)
        else $error("usb not reset on deep resume");

    cov_full_fan: cover property (@(posedge clk_i) full_fan);
    cov_irq: cover property (@(posedge clk_i) irq_o);
    cov_wake: cover property (@(posedge clk_i) wake_o);
    cov_init: cover property (@(posedge clk_i) processor_init_o);
endmodule

// file: testbench/test_pmou_bank.sv
// Purpose: self-checking bench for the power-management option bank
// Assumes: plain strobe port, pins settle in 5 cycles
// Notes:   driver notes expectations in queues, a monitor compares them
`timescale 1ns/10ps
module test_pmou_bank;
    import pmou_pkg::*;
    localparam int SLOW  = 50;
    localparam int LIMIT = 20000;
    logic        clk_i     = 1'b0;
    logic        reset_n_i = 1'b0;
    pmou_req_s   req       = '0;
    pmou_evt_s   pins      = '0;
    logic        s3        = 1'b0;
    logic        deep      = 1'b0;
    logic        wseq      = 1'b0;
    logic        ioirq     = 1'b0;
    logic        gspk      = 1'b0;
    logic        pwm       = 1'b0;
    logic        spk       = 1'b0;
    logic [3:0]  gfan      = 4'h0;
    logic [7:0]  rdata;
    logic [3:0]  fan;
    logic        spkr, hs, bm, prst, pinit, twarn, thr;
    logic        phy, ures, wake, tick, irq;
    logic [14:0] obs;
    logic [7:0]  r60, r61, r65;
    logic        irq_exp   = 1'b0;
    logic [29:0] out_q[$];
    logic [7:0]  rd_q[$];
    logic [15:0] tick_q[$];
    logic [29:0] note;
    logic [31:0] rnd;
    logic [7:0]  rw_ofs[6] = '{OFS_SPARE_5F, OFS_FAN_SPKR, OFS_CPU_THERM,
                               OFS_SPARE_63, OFS_SPARE_64, OFS_USB_CTRL};
    logic        rd_seen   = 1'b0;
    logic        snap      = 1'b0;
    int          fail_count = 0;
    int          n_checks   = 0;
    int          cycles     = 0;
    int          gap        = 0;

    // observed outputs, irq in bit 0
    assign obs = {fan, spkr, hs, bm, prst, pinit, twarn, thr, phy, ures,
                  wake, irq};

    pmou_bank #(.SLOW_CYC(SLOW)) dut (
        .clk_i                    (clk_i),
        .reset_n_i                (reset_n_i),
        .req_i                    (req),
        .rdata_o                  (rdata),
        .pins_i                   (pins),
        .sleep_s3_i               (s3),
        .sleep_deep_i             (deep),
        .wake_seq_i               (wseq),
        .ioapic_irq_i             (ioirq),
        .gpio_fan_in_i            (gfan),
        .gpio_spkr_in_i           (gspk),
        .fan_pwm_i                (pwm),
        .speaker_i                (spk),
        .fan_pin_o                (fan),
        .spkr_pin_o               (spkr),
        .ioapic_handshake_o       (hs),
        .bus_master_activity_o    (bm),
        .processor_reset_out_o    (prst),
        .processor_init_o         (pinit),
        .thermal_warning_status_o (twarn),
        .throttle_o               (thr),
        .usb_phy_powerdown_o      (phy),
        .usb_reset_o              (ures),
        .wake_o                   (wake),
        .wake_tick_o              (tick),
        .irq_o                    (irq)
    );

    // 125 MHz clock
    always #4 clk_i = ~clk_i;

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // hang guard: sized well above the tick scenarios
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, cycles, LIMIT);
            complete_run();
        end
    end

    // monitor: read data one cycle after the strobe, snapshots, tick gaps
    always @(posedge clk_i)
    begin
        if (rd_seen)
            chk({8'h00, rdata}, {8'h00, rd_q.pop_front()});
        rd_seen = req.rd;
        if (snap)
        begin
            note = out_q.pop_front();
            chk({1'b0, obs & note[14:0]}, {1'b0, note[29:15] & note[14:0]});
        end
        if (tick === 1'b1)
        begin
            if (tick_q.size() > 0)
                chk(gap[15:0], tick_q.pop_front());
            gap = 1;
        end
        else
            gap++;
    end

    // expected outputs from shadow registers and current inputs
    function automatic logic [14:0] model_out();
        logic       full;
        logic [3:0] en;
        logic [3:0] f;
        logic       wk;
        full = (r60[B_ALERT_FAN] & pins.thermal_alert)
             | (r60[B_HOT_FAN] & pins.processor_hot);
        en = {r60[B_FAN3_PIN], r60[B_FAN2_PIN], r60[B_FAN1_PIN],
              r60[B_FAN0_PIN]};
        for (int i = 0; i < 4; i++)
            f[i] = en[i] ? (full | pwm) : gfan[i];
        wk = (r65[B_RES_WAKE] & pins.usb_resume & s3)
           | (~r65[B_PHY_PDN] & pins.usb_resume & deep)
           | (r65[B_CONN_WAKE] & pins.usb_connect);
        return {f, r60[B_SPKR_PIN] ? spk : gspk, r61[B_IOAPIC_HS] & ioirq,
                r61[B_BM_MON] & (pins.bus_master_request | pins.sb_bus_master),
                r61[B_USE_PROCESSOR_RESET_OUT] & pins.system_reset,
                ~r61[B_USE_PROCESSOR_RESET_OUT] & pins.system_reset,
                r61[B_HOT_STS] & pins.processor_hot,
                r61[B_HOT_STS] & pins.processor_hot,
                r65[B_PHY_PDN] & deep,
                (r65[B_SOFT_RST] & pins.soft_bus_reset)
                | (r65[B_DEEP_RST] & pins.deep_resume), wk, irq_exp};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        req.addr  <= a;
        req.wdata <= d;
        req.wr    <= 1'b1;
        @(posedge clk_i);
        req.wr    <= 1'b0;
        shadow(a, d);
    endtask

    // shadow copies of the 0x60, 0x61 and 0x65 option registers for the output model
    function automatic void shadow(input logic [7:0] a, input logic [7:0] d);
        if (a == OFS_FAN_SPKR)
            r60 = d;
        if (a == OFS_CPU_THERM)
            r61 = d;
        if (a == OFS_USB_CTRL)
            r65 = d;
    endfunction

    // write, then read back with no idle cycle between the strobes
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
        rd_q.push_back(d);
        @(posedge clk_i);
        req.addr  <= a;
        req.wdata <= d;
        req.wr    <= 1'b1;
        @(posedge clk_i);
        req.wr    <= 1'b0;
        req.rd    <= 1'b1;
        @(posedge clk_i);
        req.rd    <= 1'b0;
        shadow(a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        rd_q.push_back(exp);
        @(posedge clk_i);
        req.addr <= a;
        req.rd   <= 1'b1;
        @(posedge clk_i);
        req.rd   <= 1'b0;
    endtask

    task automatic settle();
        repeat (5) @(posedge clk_i);
    endtask

    task automatic snap_out(input logic [14:0] mask);
        out_q.push_back({model_out(), mask});
        @(posedge clk_i);
        snap <= 1'b1;
        @(posedge clk_i);
        snap <= 1'b0;
    endtask

    task automatic wait_tick();
        do
            @(posedge clk_i);
        while (tick !== 1'b1);
    endtask

    task automatic do_reset();
        pins <= '0;
        @(posedge clk_i);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        r60 = RST_FAN_SPKR;
        r61 = RST_CPU_THERM;
        r65 = RST_USB_CTRL;
        irq_exp = 1'b0;
    endtask

    task automatic check_defaults();
        rd(OFS_SPARE_5F, RST_SPARE_5F);
        rd(OFS_FAN_SPKR, RST_FAN_SPKR);
        rd(OFS_CPU_THERM, 8'h08);
        rd(OFS_SCI_MIRROR, 8'h00);
        rd(OFS_SPARE_63, 8'h05);
        rd(OFS_SPARE_64, RST_SPARE_64);
        rd(OFS_USB_CTRL, 8'h34);
        rd(OFS_IRQ_STATUS, 8'h00);
        rd(OFS_IRQ_MASK, 8'h00);
        rd(8'h66, 8'h00);
    endtask

    initial
    begin
        void'($urandom(32'h5232));
        do_reset();
        check_defaults();
        // readback with random data, reserved places are plain storage
        for (int i = 0; i < 6; i++)
        begin
            rnd = $urandom;
            wr_rd(rw_ofs[i], rnd[7:0]);
        end
        wr(OFS_SCI_MIRROR, 8'hff);
        rd(OFS_SCI_MIRROR, 8'h00);
        wr(8'h66, 8'haa);
        rd(8'h66, 8'h00);
        // interrupt raised, held sticky, cleared, then masked
        wr(OFS_IRQ_MASK, 8'h01);
        wr(OFS_CPU_THERM, 8'h10);
        pins.processor_hot <= 1'b1;
        irq_exp = 1'b1;
        settle();
        snap_out(15'h0031);
        pins.processor_hot <= 1'b0;
        settle();
        rd(OFS_IRQ_STATUS, 8'h01);
        snap_out(15'h0001);
        wr(OFS_IRQ_STATUS, 8'h01);
        irq_exp = 1'b0;
        settle();
        rd(OFS_IRQ_STATUS, 8'h00);
        snap_out(15'h0001);
        wr(OFS_IRQ_MASK, 8'h00);
        pins.processor_hot <= 1'b1;
        settle();
        rd(OFS_IRQ_STATUS, 8'h01);
        snap_out(15'h0001);
        pins.processor_hot <= 1'b0;
        wr(OFS_IRQ_STATUS, 8'h07);
        // processor reset against init selection
        for (int i = 0; i < 2; i++)
        begin
            pins.system_reset <= 1'b0;
            settle();
            wr(OFS_CPU_THERM, i == 0 ? 8'h08 : 8'h00);
            pins.system_reset <= 1'b1;
            settle();
            snap_out(15'h00c0);
        end
        // random sweep over options and input levels
        repeat (40)
        begin
            // quiet pins, then drop sticky status so twarn follows the pin
            pins <= '0;
            settle();
            wr(OFS_IRQ_STATUS, 8'h07);
            rnd = $urandom;
            wr(OFS_FAN_SPKR, rnd[7:0]);
            wr(OFS_CPU_THERM, rnd[15:8]);
            wr(OFS_USB_CTRL, rnd[23:16]);
            rnd = $urandom;
            pins  <= rnd[9:0] & 10'h3fd;
            s3    <= rnd[10];
            deep  <= rnd[11];
            ioirq <= rnd[12];
            gspk  <= rnd[13];
            gfan  <= rnd[17:14];
            pwm   <= rnd[18];
            spk   <= rnd[19];
            settle();
            snap_out(15'h7ffe);
            rd(OFS_SCI_MIRROR, {7'h00, pins.sci});
        end
        // sequencing tick period, slow then fast
        wseq <= 1'b1;
        wr(OFS_USB_CTRL, 8'h80);
        wait_tick();
        wait_tick();
        @(posedge clk_i);
        tick_q.push_back(16'(SLOW));
        wait_tick();
        wr(OFS_USB_CTRL, 8'h00);
        wait_tick();
        wait_tick();
        @(posedge clk_i);
        tick_q.push_back(16'(TICK_FAST_CYC));
        wait_tick();
        wseq <= 1'b0;
        // second reset in mid-run restores defaults
        do_reset();
        check_defaults();
        repeat (3) @(posedge clk_i);
        complete_run();
    end
endmodule
